// ==== src/tcd_ctrl.sv ====
// tcd_ctrl: control-2 and interrupt/dma enable logic of a single-channel
// timer with one complementary pair, reached over axi4-lite.
// assumes counter, compare and break logic outside supply event pulses
// on aclk; the pins for those events are already synchronous.
`timescale 1ns/1ns
// Operation
// (R1) idle complementary output after dead-time
// (R2) idle primary output, after dead-time
// (R3) lock level blocks idle-bit writes
// (R4) dma trigger select: compare or update
// (R5) preload channel bits until commutation generate
// (R6) preload only on complementary channels
// (R7) channel1 dma only when enabled
// (R8) update dma only when enabled
// (R9) break interrupt gated by enable
// (R10) commutation interrupt gated by enable
// (R11) channel1 interrupt gated by enable
// (R12) update interrupt gated by enable
// (R13) software writes reserved bits as zero
// (R14) commutation sets the commutation flag
// (R15) irq is or of flag-enable pairs
module tcd_ctrl
    import tcd_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    // axi4-lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // timer events, one-cycle pulses; then dead-time count and run levels
    input wire logic update_event,
    input wire logic ch1_event,
    input wire logic break_event,
    input wire logic [7:0] dead_cycles,
    input wire logic run_primary,
    input wire logic run_comp,
    // outputs
    output logic channel1_primary_output,
    output logic channel1_complementary_output,
    output logic [2:0] active_mode,
    output logic active_enable,
    output logic active_comp_enable,
    output logic ch1_dma_req,
    output logic upd_dma_req,
    output logic irq
);

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic [7:0] awaddr;
        logic aw_have;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic w_have;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [31:0] idle_ctrl;
        logic [31:0] irq_en;
        logic [31:0] status;
        logic [31:0] chan_pre;
        logic [31:0] chan_act;
        logic [31:0] out_ctrl;
        logic ch1_dma;
        logic upd_dma;
        logic irq;
    } tcd_st_t;

    tcd_st_t st;
    tcd_st_t next_st;

    logic [31:0] wmask;
    logic [31:0] wval;
    logic wr_go;
    logic com_pulse;
    logic [31:0] flags_set;

    ////////////////////////////////////////////////////////////////////////
    // byte-lane mask from the strobes
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            wmask[i*8 +: 8] = {8{st.wstrb[i]}};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // main next-state logic
    always_comb begin
        next_st = st;
        wval = 32'h0000_0000;
        com_pulse = 1'b0;
        flags_set = 32'h0000_0000;
        wr_go = st.aw_have && st.w_have && !st.bvalid;

        // address and data taken independently, one write in flight
        if (s_axi_awvalid && st.awready) begin
            next_st.awaddr = s_axi_awaddr;
            next_st.aw_have = 1'b1;
            next_st.awready = 1'b0;
        end
        if (s_axi_wvalid && st.wready) begin
            next_st.wdata = s_axi_wdata;
            next_st.wstrb = s_axi_wstrb;
            next_st.w_have = 1'b1;
            next_st.wready = 1'b0;
        end

        // write commit
        if (wr_go) begin
            next_st.aw_have = 1'b0;
            next_st.w_have = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = RESP_OKAY;
            unique case (st.awaddr)
                OFS_IDLE_PRELOAD: begin
                    wval = (st.idle_ctrl & ~wmask) | (st.wdata & wmask);
                    // nonzero lock level freezes both idle bits
                    if (st.out_ctrl[B_LOCK_LO +: 2] != 2'h0) begin
                        wval[B_COMP_IDLE] = st.idle_ctrl[B_COMP_IDLE]; // R3
                        wval[B_PRIM_IDLE] = st.idle_ctrl[B_PRIM_IDLE]; // R3
                    end
                    next_st.idle_ctrl = wval & 32'h0000_0309;
                end
                OFS_IRQ_DMA_EN: begin
                    wval = (st.irq_en & ~wmask) | (st.wdata & wmask);
                    next_st.irq_en = wval & IRQ_EN_MASK;
                end
                OFS_STATUS: begin
                    // write zero clears; a one leaves the flag alone
                    wval = st.wdata | ~wmask;
                    next_st.status = st.status & wval;
                end
                OFS_CHAN_CTRL: begin
                    wval = (st.chan_pre & ~wmask) | (st.wdata & wmask);
                    next_st.chan_pre = wval & CHAN_CTRL_MASK;
                    // without preload the write goes live at once
                    if (!st.idle_ctrl[B_PRELOAD]) begin
                        next_st.chan_act = wval & CHAN_CTRL_MASK; // R5
                    end
                end
                OFS_EVENT_GEN: begin
                    // self-clearing; nothing is stored
                    if (st.wstrb[0] && st.wdata[B_COM_GEN]) begin
                        com_pulse = 1'b1;
                    end
                end
                OFS_OUT_CTRL: begin
                    wval = (st.out_ctrl & ~wmask) | (st.wdata & wmask);
                    // lock level holds once it is nonzero, until reset
                    if (st.out_ctrl[B_LOCK_LO +: 2] != 2'h0) begin
                        wval[B_LOCK_LO +: 2] = st.out_ctrl[B_LOCK_LO +: 2];
                    end
                    next_st.out_ctrl = wval & 32'h0000_8300;
                end
                default: begin
                    next_st.bresp = RESP_SLVERR;
                end
            endcase
        end

        // channel 1 has a complementary output, so preload applies to it
        if (com_pulse && st.idle_ctrl[B_PRELOAD]) begin
            next_st.chan_act = st.chan_pre; // R5 R6
        end
        if (com_pulse) begin
            flags_set[B_COM_FLAG] = 1'b1; // R14
        end
        flags_set[B_UPD_FLAG] = update_event;
        flags_set[B_CH1_FLAG] = ch1_event;
        flags_set[B_BRK_FLAG] = break_event;
        // set wins over a clear in the same cycle
        next_st.status = next_st.status | flags_set;

        // write response handshake
        if (st.bvalid && s_axi_bready) begin
            next_st.bvalid = 1'b0;
            next_st.awready = 1'b1;
            next_st.wready = 1'b1;
        end

        // read channel
        if (s_axi_arvalid && st.arready) begin
            next_st.arready = 1'b0;
            next_st.rvalid = 1'b1;
            next_st.rresp = RESP_OKAY;
            unique case (s_axi_araddr)
                OFS_IDLE_PRELOAD: next_st.rdata = st.idle_ctrl;
                OFS_IRQ_DMA_EN: next_st.rdata = st.irq_en;
                OFS_STATUS: next_st.rdata = st.status;
                OFS_CHAN_CTRL: next_st.rdata = st.chan_act;
                OFS_EVENT_GEN: next_st.rdata = 32'h0000_0000;
                OFS_OUT_CTRL: next_st.rdata = st.out_ctrl;
                default: begin
                    next_st.rdata = 32'h0000_0000;
                    next_st.rresp = RESP_SLVERR;
                end
            endcase
        end
        if (st.rvalid && s_axi_rready) begin
            next_st.rvalid = 1'b0;
            next_st.arready = 1'b1;
        end

        // dma: select picks the channel-1 request source
        if (st.idle_ctrl[B_DMA_SEL]) begin
            next_st.ch1_dma = update_event // R4
                && st.irq_en[B_CH1_DMA_EN]; // R7
        end else begin
            next_st.ch1_dma = ch1_event // R4
                && st.irq_en[B_CH1_DMA_EN]; // R7
        end
        next_st.upd_dma = update_event && st.irq_en[B_UPD_DMA_EN]; // R8

        // interrupt is a level: held while any enabled flag stands
        next_st.irq = (st.status[B_BRK_FLAG] && st.irq_en[B_BRK_IRQ_EN]) // R9
            || (st.status[B_COM_FLAG] && st.irq_en[B_COM_IRQ_EN]) // R10
            || (st.status[B_CH1_FLAG] && st.irq_en[B_CH1_IRQ_EN]) // R11
            || (st.status[B_UPD_FLAG] && st.irq_en[B_UPD_IRQ_EN]); // R15 R12
    end

    ////////////////////////////////////////////////////////////////////////
    // state register; clock enable freezes everything
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '0;
            st.awready <= 1'b1;
            st.wready <= 1'b1;
            st.arready <= 1'b1;
            st.idle_ctrl <= RST_IDLE_PRELOAD;
            st.irq_en <= RST_IRQ_DMA_EN;
        end else if (clk_en) begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // output pair stage
    tcd_idle_out tcd_idle_out_i (
        .aclk(aclk),
        .aresetn(aresetn),
        .clk_en(clk_en),
        .main_oe(st.out_ctrl[B_MAIN_OE]),
        .run_primary(run_primary && st.chan_act[B_CH_EN]),
        .run_comp(run_comp && st.chan_act[B_CH_COMP_EN]),
        .primary_idle_level(st.idle_ctrl[B_PRIM_IDLE]), // R2
        .complementary_idle_level(st.idle_ctrl[B_COMP_IDLE]), // R1
        .dead_cycles(dead_cycles),
        .channel1_primary_output(channel1_primary_output),
        .channel1_complementary_output(channel1_complementary_output)
    );

    assign s_axi_awready = st.awready;
    assign s_axi_wready = st.wready;
    assign s_axi_bvalid = st.bvalid;
    assign s_axi_bresp = st.bresp;
    assign s_axi_arready = st.arready;
    assign s_axi_rvalid = st.rvalid;
    assign s_axi_rdata = st.rdata;
    assign s_axi_rresp = st.rresp;
    assign active_mode = st.chan_act[B_CH_MODE_LO +: W_CH_MODE];
    assign active_enable = st.chan_act[B_CH_EN];
    assign active_comp_enable = st.chan_act[B_CH_COMP_EN];
    assign ch1_dma_req = st.ch1_dma;
    assign upd_dma_req = st.upd_dma;
    assign irq = st.irq;

endmodule : tcd_ctrl

// ==== shared/tcd_pkg.sv ====
// tcd_pkg: register map, field positions, reset values and timing counts
// for the timer control-2 / interrupt-dma-enable block.
// assumes a 32-bit axi4-lite register bus with word-aligned registers.
package tcd_pkg;

    // register byte offsets
    localparam logic [7:0] OFS_IDLE_PRELOAD = 8'h04;
    localparam logic [7:0] OFS_IRQ_DMA_EN = 8'h0C;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_CHAN_CTRL = 8'h20;
    localparam logic [7:0] OFS_EVENT_GEN = 8'h14;
    localparam logic [7:0] OFS_OUT_CTRL = 8'h44;

    // output_idle_and_preload_control fields
    localparam int B_COMP_IDLE = 9;
    localparam int B_PRIM_IDLE = 8;
    localparam int B_DMA_SEL = 3;
    localparam int B_PRELOAD = 0;

    // interrupt_dma_enable fields
    localparam int B_CH1_DMA_EN = 9;
    localparam int B_UPD_DMA_EN = 8;
    localparam int B_BRK_IRQ_EN = 7;
    localparam int B_COM_IRQ_EN = 5;
    localparam int B_CH1_IRQ_EN = 1;
    localparam int B_UPD_IRQ_EN = 0;
    localparam logic [31:0] IRQ_EN_MASK = 32'h0000_03A3;

    // status flag positions (same layout as the enables)
    localparam int B_BRK_FLAG = 7;
    localparam int B_COM_FLAG = 5;
    localparam int B_CH1_FLAG = 1;
    localparam int B_UPD_FLAG = 0;

    // channel control: active enables and mode
    localparam int B_CH_EN = 0;
    localparam int B_CH_COMP_EN = 2;
    localparam int B_CH_MODE_LO = 4;
    localparam int W_CH_MODE = 3;
    localparam logic [31:0] CHAN_CTRL_MASK = 32'h0000_0075;

    // event generation: commutation generate bit
    localparam int B_COM_GEN = 5;

    // output control: lock level field and main output enable
    localparam int B_LOCK_LO = 8;
    localparam int B_MAIN_OE = 15;

    // reset values
    localparam logic [31:0] RST_IDLE_PRELOAD = 32'h0000_0000;
    localparam logic [31:0] RST_IRQ_DMA_EN = 32'h0000_0000;

    // dead-time count in timer clocks
    localparam logic [7:0] DEAD_CYCLES_DEF = 8'h04;

    // axi response codes
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : tcd_pkg

// ==== src/tcd_idle_out.sv ====
// tcd_idle_out: channel-1 output pair stage with idle levels and dead-time.
// assumes the caller supplies synchronous controls on the same clock.
`timescale 1ns/1ns
module tcd_idle_out
    import tcd_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clk_en,
    input wire logic main_oe,
    input wire logic run_primary,
    input wire logic run_comp,
    input wire logic primary_idle_level,
    input wire logic complementary_idle_level,
    input wire logic [7:0] dead_cycles,
    output logic channel1_primary_output,
    output logic channel1_complementary_output
);

    typedef struct packed {
        logic [7:0] dead_cnt;
        logic idle_seen;
        logic prim;
        logic comp;
    } tcd_io_t;

    tcd_io_t st;
    tcd_io_t next_st;

    ////////////////////////////////////////////////////////////////////////
    // outputs go low first, then to idle levels once the dead-time runs out
    always_comb begin
        next_st = st;
        if (main_oe) begin
            next_st.dead_cnt = dead_cycles;
            next_st.idle_seen = 1'b0;
            next_st.prim = run_primary;
            next_st.comp = run_comp;
        end else if (st.dead_cnt != 8'h00) begin
            // both low during dead-time avoids shoot-through
            next_st.dead_cnt = st.dead_cnt - 8'h01;
            next_st.prim = 1'b0;
            next_st.comp = 1'b0;
        end else begin
            next_st.idle_seen = 1'b1;
            next_st.prim = primary_idle_level; // R2
            next_st.comp = complementary_idle_level; // R1
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '0;
        end else if (clk_en) begin
            st <= next_st;
        end
    end

    assign channel1_primary_output = st.prim;
    assign channel1_complementary_output = st.comp;

endmodule : tcd_idle_out

// ==== tb/tcd_ctrl_asserts.sv ====
// checker: bus answer timing, dma and irq gating of tcd_ctrl
// assumes address and data offered together; byte strobes are honoured
`timescale 1ns/1ns
module tcd_ctrl_asserts
    import tcd_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic update_event,
    input wire logic ch1_event,
    input wire logic ch1_dma_req,
    input wire logic upd_dma_req,
    input wire logic irq
);
logic [1:0] tk_q;
logic [31:0] wd_q;
logic [3:0] ws_q;
logic [9:0] en_sh;
logic sel_sh;
wire tk = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
wire ar = s_axi_arvalid && s_axi_arready;
wire bh = s_axi_bvalid && s_axi_bready;
////////////////////////////////////////////////////////////////////////
// shadow of enables and dma select; lands on the commit edge, one after
// the take, so it lines up with the design's own copy
always_ff @(posedge aclk) begin
    tk_q <= aresetn ? {tk && s_axi_awaddr == OFS_IRQ_DMA_EN,
        tk && s_axi_awaddr == OFS_IDLE_PRELOAD} : 2'h0;
    wd_q <= s_axi_wdata;
    ws_q <= s_axi_wstrb;
    // only strobed byte lanes move, reserved enable bits read as zero
    if (!aresetn) begin
        en_sh <= 10'h000;
    end else if (tk_q[1]) begin
        if (ws_q[0]) en_sh[7:0] <= wd_q[7:0] & IRQ_EN_MASK[7:0];
        if (ws_q[1]) en_sh[9:8] <= wd_q[9:8];
    end
    if (!aresetn) sel_sh <= 1'h0;
    else if (tk_q[0] && ws_q[0]) sel_sh <= wd_q[B_DMA_SEL];
end
////////////////////////////////////////////////////////////////////////
default clocking dc @(posedge aclk); endclocking
default disable iff (!aresetn);
property p_wr_resp; tk |-> ##2 s_axi_bvalid; endproperty
a_wr_resp: assert property (p_wr_resp) else $error("write answer late");
property p_wr_busy; tk |=> !s_axi_awready [*2]; endproperty
a_wr_busy: assert property (p_wr_busy) else $error("write ready early");
property p_rd_resp; ar |=> s_axi_rvalid && !s_axi_arready; endproperty
a_rd_resp: assert property (p_rd_resp) else $error("read answer late");
property p_b_done; bh |=> !s_axi_bvalid && s_axi_wready; endproperty
a_b_done: assert property (p_b_done) else $error("write did not close");
property p_upd_dma;
    upd_dma_req == ($past(update_event) && $past(en_sh[8]));
endproperty
a_upd_dma: assert property (p_upd_dma) else $error("update dma wrong");
property p_ch1_dma;
    ch1_dma_req == ($past(en_sh[9]) &&
        ($past(sel_sh) ? $past(update_event) : $past(ch1_event)));
endproperty
a_ch1_dma: assert property (p_ch1_dma) else $error("ch1 dma wrong");
property p_irq_gate; irq |-> |($past(en_sh) & 10'h0A3); endproperty
a_irq_gate: assert property (p_irq_gate) else $error("irq unmasked");
property p_irq_ev;
    update_event && en_sh[0] || ch1_event && en_sh[1] |-> ##2 irq;
endproperty
a_irq_ev: assert property (p_irq_ev) else $error("irq missing");
c_ch1: cover property (ch1_dma_req);
c_upd: cover property (upd_dma_req);
c_irq: cover property (irq);
endmodule : tcd_ctrl_asserts

bind tcd_ctrl tcd_ctrl_asserts tcd_ctrl_asserts_i (.aclk, .aresetn,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .update_event,
    .ch1_event, .ch1_dma_req, .upd_dma_req, .irq);

// ==== tb/tb_tcd_ctrl.sv ====
// bench for tcd_ctrl: register map, dma select and gating, irq masking,
// channel preload, idle levels, lock and reset
// assumes the checker file is compiled alongside and binds itself
`timescale 1ns/1ns
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin \
    error_cnt++; $display("[ERR] %0t got %0h exp %0h", $time, a, b); end end
module tb_tcd_ctrl
    import tcd_pkg::*;
;
typedef struct packed {
    logic sel;
    logic [9:0] en;
    logic [1:0] k;
    logic [2:0] ex;
} tcd_row_t;
logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq, prim, comp;
logic ch1_dma_req, upd_dma_req, act_en, act_comp;
logic [7:0] s_axi_awaddr, s_axi_araddr;
logic [31:0] s_axi_wdata, s_axi_rdata;
logic [1:0] s_axi_bresp, s_axi_rresp;
logic [3:0] s_axi_wstrb;
logic [2:0] ev, act_mode;
int error_cnt, num_checks;
// dma select, enables, event (update, channel, break, generate) and the
// {channel dma, update dma, irq} each should give
tcd_row_t rows [12] = '{
    '{1'h0, 10'h200, 2'h1, 3'h4}, '{1'h0, 10'h200, 2'h0, 3'h0},
    '{1'h1, 10'h200, 2'h0, 3'h4}, '{1'h1, 10'h300, 2'h1, 3'h0},
    '{1'h0, 10'h100, 2'h0, 3'h2}, '{1'h0, 10'h000, 2'h1, 3'h0},
    '{1'h0, 10'h001, 2'h0, 3'h1}, '{1'h0, 10'h002, 2'h1, 3'h1},
    '{1'h0, 10'h080, 2'h2, 3'h1}, '{1'h0, 10'h020, 2'h3, 3'h1},
    '{1'h0, 10'h022, 2'h0, 3'h0}, '{1'h0, 10'h001, 2'h2, 3'h0}};

tcd_ctrl tcd_ctrl_i (.aclk, .aresetn, .clk_en(1'h1), .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .update_event(ev[0]), .ch1_event(ev[1]), .break_event(ev[2]),
    .dead_cycles(8'h08), .run_primary(1'h1), .run_comp(1'h0),
    .channel1_primary_output(prim), .channel1_complementary_output(comp),
    .active_mode(act_mode), .active_enable(act_en),
    .active_comp_enable(act_comp), .ch1_dma_req, .upd_dma_req, .irq);

initial begin
    aclk = 1'h0;
    forever #5 aclk = ~aclk;
end
////////////////////////////////////////////////////////////////////////
task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
        $display("All tests passed");
    end else begin
        $display("Some tests failed");
    end
    $finish;
endtask : stop_test

task automatic do_reset;
    aresetn <= 1'h0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
endtask : do_reset

// one write (w=1) or read; every channel is held until its own handshake
task automatic bus(input logic w, input logic [7:0] a,
        input logic [31:0] d, input logic [1:0] rs);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_araddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{w}};
    {s_axi_arvalid, s_axi_rready} <= {2{!w}};
    for (n = 0; n < 100; n++) begin
        @(posedge aclk);
        if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
        if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
        if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
        if (s_axi_bvalid && s_axi_bready || s_axi_rvalid && s_axi_rready)
            break;
    end
    {s_axi_bready, s_axi_rready} <= 2'h0;
    if (n == 100) begin
        error_cnt++;
        stop_test();
    end else begin
        `CHK(w ? s_axi_bresp : s_axi_rresp, rs)
        if (!w && rs == RESP_OKAY) `CHK(s_axi_rdata, d)
    end
endtask : bus

// k 0..2 pulses an event pin for one cycle; 3 writes commutation generate
task automatic pulse(input logic [1:0] k);
    if (k == 2'h3) begin
        bus(1'h1, OFS_EVENT_GEN, 32'h20, RESP_OKAY);
    end else begin
        @(posedge aclk);
        ev <= 3'h1 << k;
        @(posedge aclk);
        ev <= 3'h0;
    end
    #1;
endtask : pulse
////////////////////////////////////////////////////////////////////////
initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, ev} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    error_cnt = 0;
    num_checks = 0;
    do_reset();
    // reset values, plain access and an unmapped word
    bus(1'h0, OFS_IDLE_PRELOAD, RST_IDLE_PRELOAD, RESP_OKAY);
    bus(1'h0, OFS_IRQ_DMA_EN, RST_IRQ_DMA_EN, RESP_OKAY);
    bus(1'h1, OFS_IRQ_DMA_EN, 32'h3A3, RESP_OKAY);
    bus(1'h0, OFS_IRQ_DMA_EN, 32'h3A3, RESP_OKAY);
    bus(1'h1, 8'h08, 32'h1, RESP_SLVERR);
    bus(1'h0, 8'h08, 32'h0, RESP_SLVERR);
    // preload off applies at once; on, only a generate moves bits across
    bus(1'h1, OFS_CHAN_CTRL, 32'h75, RESP_OKAY);
    `CHK({act_mode, act_comp, act_en}, 5'h1F)
    bus(1'h1, OFS_IDLE_PRELOAD, 32'h1, RESP_OKAY);
    bus(1'h1, OFS_CHAN_CTRL, 32'h10, RESP_OKAY);
    bus(1'h0, OFS_CHAN_CTRL, 32'h75, RESP_OKAY);
    bus(1'h1, OFS_EVENT_GEN, 32'h20, RESP_OKAY);
    repeat (2) @(posedge aclk);
    `CHK({act_mode, act_comp, act_en}, 5'h04)
    bus(1'h0, OFS_STATUS, 32'h20, RESP_OKAY);
    // event table; flags cleared first so each row stands alone
    foreach (rows[j]) begin
        bus(1'h1, OFS_IDLE_PRELOAD, {28'h0, rows[j].sel, 3'h0}, RESP_OKAY);
        bus(1'h1, OFS_IRQ_DMA_EN, {22'h0, rows[j].en}, RESP_OKAY);
        bus(1'h1, OFS_STATUS, 32'h0, RESP_OKAY);
        pulse(rows[j].k);
        `CHK(ch1_dma_req, rows[j].ex[2])
        `CHK(upd_dma_req, rows[j].ex[1])
        repeat (3) @(posedge aclk);
        `CHK(irq, rows[j].ex[0])
    end
    // outputs stay low through the dead-time, then show the idle levels
    bus(1'h1, OFS_OUT_CTRL, 32'h8000, RESP_OKAY);
    bus(1'h1, OFS_IDLE_PRELOAD, 32'h300, RESP_OKAY);
    bus(1'h1, OFS_OUT_CTRL, 32'h0, RESP_OKAY);
    repeat (3) @(posedge aclk);
    `CHK({prim, comp}, 2'h0)
    repeat (12) @(posedge aclk);
    `CHK({prim, comp}, 2'h3)
    bus(1'h1, OFS_IDLE_PRELOAD, 32'h200, RESP_OKAY);
    repeat (12) @(posedge aclk);
    `CHK({prim, comp}, 2'h1)
    // lock level 1 freezes idle bits but not the dma select
    bus(1'h1, OFS_OUT_CTRL, 32'h100, RESP_OKAY);
    bus(1'h1, OFS_IDLE_PRELOAD, 32'h8, RESP_OKAY);
    bus(1'h0, OFS_IDLE_PRELOAD, 32'h208, RESP_OKAY);
    // one strobed byte lane leaves the upper dma enables untouched
    s_axi_wstrb <= 4'h1;
    bus(1'h1, OFS_IRQ_DMA_EN, 32'h302, RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    bus(1'h0, OFS_IRQ_DMA_EN, 32'h002, RESP_OKAY);
    // a second reset mid-run clears the lock and the enables
    do_reset();
    `CHK(irq, 1'h0)
    bus(1'h0, OFS_IRQ_DMA_EN, RST_IRQ_DMA_EN, RESP_OKAY);
    bus(1'h1, OFS_IDLE_PRELOAD, 32'h300, RESP_OKAY);
    bus(1'h0, OFS_IDLE_PRELOAD, 32'h300, RESP_OKAY);
    stop_test();
end
endmodule : tb_tcd_ctrl
